// ===== src/tac_core.sv
// Operation
// RULE_01: control byte goes to exactly one register
// RULE_02: top five zero loads channel select
// RULE_03: channel code drives the input multiplexer
// RULE_04: code seven selects the bandgap reference
// RULE_05: channel select resets to temperature sensor
// RULE_06: any top bit set loads threshold
// RULE_07: temperature result above threshold drives alarm low
// RULE_08: host encodes threshold as Celsius plus 103
// RULE_09: host keeps threshold within sensor span
// RULE_10: alarm releases on read or cooler result
// RULE_11: threshold resets to 153, fifty degrees
// RULE_12: strobe falling edge starts hold and conversion
// RULE_13: busy lasts 9 or 27 microseconds
// RULE_14: conversion timing comes from internal clock
// RULE_15: acquisition follows conversion, settles in 100 ns
// RULE_16: host waits 400 ns before next start
// RULE_17: result is straight binary code
// RULE_18: temperature code is quarter degrees plus offset
// RULE_19: reference sensor codes follow linear mapping
// RULE_20: alarm clears on read select rising edge
// RULE_21: strobe low at end powers down
// RULE_22: host waits 100 ns after read
// RULE_23: reading erases the result
// RULE_24: only temperature conversions touch the alarm
// RULE_25: result latched when busy falls
`timescale 1ns/100ps
module tac_core
  import tac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic rd_wr,
  input wire logic serial_din,
  output logic serial_dout,
  output logic serial_dout_oe,
  input wire logic convert_strobe_n,
  input wire logic [RES_W-1:0] adc_code,
  output logic [2:0] channel_sel,
  output logic bandgap_sel,
  output logic busy,
  output logic hold,
  output logic acquire_settled,
  output logic power_down,
  output logic over_temp_alarm_n
);

  // ----------------------------------------------------------------
  // serial port in the sclk domain
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] wr_byte;
  logic wr_toggle;
  logic [RES_W-1:0] rd_data;

  tac_serial tac_serial_inst (
    .sclk(sclk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .rd_wr(rd_wr),
    .serial_din(serial_din),
    .rd_data(rd_data),
    .serial_dout(serial_dout),
    .serial_dout_oe(serial_dout_oe),
    .wr_byte(wr_byte),
    .wr_toggle(wr_toggle)
  );

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic cv_m, cv_s, cv_d;
  logic rw_m, rw_s, rw_d;
  logic tg_m, tg_s, tg_d;

  // third stage only feeds the edge detectors
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cv_m <= 1'b1;
      cv_s <= 1'b1;
      cv_d <= 1'b1;
      rw_m <= 1'b0;
      rw_s <= 1'b0;
      rw_d <= 1'b0;
      tg_m <= 1'b0;
      tg_s <= 1'b0;
      tg_d <= 1'b0;
    end else begin
      cv_m <= convert_strobe_n;
      cv_s <= cv_m;
      cv_d <= cv_s;
      rw_m <= rd_wr;
      rw_s <= rw_m;
      rw_d <= rw_s;
      tg_m <= wr_toggle;
      tg_s <= tg_m;
      tg_d <= tg_s;
    end
  end

  logic strobe_fall, strobe_rise, rd_rise, rd_fall, wr_evt;
  assign strobe_fall = cv_d & ~cv_s;
  assign strobe_rise = ~cv_d & cv_s;
  assign rd_rise = ~rw_d & rw_s;
  assign rd_fall = rw_d & ~rw_s;
  assign wr_evt = tg_d ^ tg_s;

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  tac_conv_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [2:0] settle, next_settle;
  logic conv_temp, next_conv_temp;
  logic [RES_W-1:0] result, next_result;
  logic [RES_W-1:0] next_rd_data;
  logic conv_end;

  assign conv_end = (state == CV_CONV) && (cnt == '0);

  // timing runs purely off clk_sys, sclk never enters here
  // RULE_14: internal conversion timing
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_settle = settle;
    next_conv_temp = conv_temp;
    next_result = result;
    unique case (state)
      CV_ACQ: begin
        if (settle != 3'h0) begin
          next_settle = settle - 3'h1;
        end
        // RULE_12: start on strobe fall
        if (strobe_fall) begin
          next_state = CV_CONV;
          next_conv_temp = (channel_sel == CH_TEMP);
          // RULE_13: length by channel
          next_cnt = (channel_sel == CH_TEMP) ? CONV_TEMP_CYC - 11'h1 : CONV_ADC_CYC - 11'h1;
        end
      end
      CV_CONV: begin
        next_cnt = cnt - 11'h1;
        if (cnt == '0) begin
          // RULE_17 RULE_18 RULE_19: code kept as converted
          // RULE_25: latch at busy fall
          next_result = adc_code;
          // RULE_15: settling restarts
          next_settle = SETTLE_CYC;
          // RULE_21: strobe still low
          next_state = cv_s ? CV_ACQ : CV_PDOWN;
        end
      end
      CV_PDOWN: begin
        if (strobe_rise) begin
          next_state = CV_ACQ;
        end
      end
    endcase
    // RULE_23: read erases result
    if (rd_fall && !conv_end) begin
      next_result = '0;
    end
  end

  // readout copy frozen while the select line is high
  always_comb begin
    next_rd_data = rw_s ? rd_data : result;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= CV_ACQ;
      cnt <= '0;
      settle <= SETTLE_CYC;
      conv_temp <= 1'b0;
      result <= '0;
      rd_data <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      settle <= next_settle;
      conv_temp <= next_conv_temp;
      result <= next_result;
      rd_data <= next_rd_data;
    end
  end

  assign busy = (state == CV_CONV);
  assign hold = (state == CV_CONV);
  assign power_down = (state == CV_PDOWN);
  assign acquire_settled = (state == CV_ACQ) && (settle == 3'h0);

  // ----------------------------------------------------------------
  // control registers and alarm
  // ----------------------------------------------------------------
  logic [7:0] alarm_threshold_reg, next_thr;
  logic [2:0] next_channel;
  logic next_alarm_n;
  logic temp_hot;

  // RULE_07: upper eight bits, strictly greater
  assign temp_hot = adc_code[RES_W-1:2] > alarm_threshold_reg;

  always_comb begin
    next_channel = channel_sel;
    next_thr = alarm_threshold_reg;
    next_alarm_n = over_temp_alarm_n;
    // RULE_01: route byte by its top bits
    if (wr_evt) begin
      if (wr_byte[SEL_MSB:SEL_LSB] == SEL_ADDR) begin
        // RULE_02: channel select load
        next_channel = wr_byte[2:0];
      end else begin
        // RULE_06: threshold load
        next_thr = wr_byte;
      end
    end
    // RULE_20: read select rise releases
    if (rd_rise) begin
      next_alarm_n = 1'b1;
    end
    // RULE_24: temperature channel only
    if (conv_end && conv_temp) begin
      // RULE_10: cooler result releases, a hot one wins over a read
      next_alarm_n = ~temp_hot;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // RULE_05: temperature sensor default
      channel_sel <= CH_RESET;
      // RULE_11: fifty degree default
      alarm_threshold_reg <= THR_RESET;
      over_temp_alarm_n <= 1'b1;
    end else begin
      // RULE_03: code steers input mux
      channel_sel <= next_channel;
      alarm_threshold_reg <= next_thr;
      over_temp_alarm_n <= next_alarm_n;
    end
  end

  // RULE_04: bandgap routing
  assign bandgap_sel = (channel_sel == CH_BANDGAP);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] busy_len;

  // helper: length of the current busy window
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_len <= '0;
    end else begin
      busy_len <= busy ? busy_len + 11'h1 : '0;
    end
  end

  sequence s_settling;
    !acquire_settled [*5] ##1 (acquire_settled || busy);
  endsequence

  AST_CHAN_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    wr_evt && wr_byte[7:3] == 5'h00 |=> channel_sel == $past(wr_byte[2:0])
      && $stable(alarm_threshold_reg))
    else $error("channel select not loaded from control byte");

  AST_THR_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
    wr_evt && wr_byte[7:3] != 5'h00 |=> alarm_threshold_reg == $past(wr_byte)
      && $stable(channel_sel))
    else $error("threshold not loaded from control byte");

  AST_BUSY_START: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_12
    state == CV_ACQ && strobe_fall |=> busy && hold)
    else $error("conversion did not start on strobe fall");

  AST_BUSY_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_13
    conv_end |-> busy_len == (conv_temp ? CONV_TEMP_CYC - 11'h1 : CONV_ADC_CYC - 11'h1))
    else $error("busy length wrong");

  AST_ALARM_SET: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
    conv_end && conv_temp && temp_hot |=> !over_temp_alarm_n)
    else $error("alarm not asserted on hot result");

  AST_ALARM_OTHER: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_24
    conv_end && !conv_temp && !rd_rise |=> $stable(over_temp_alarm_n))
    else $error("alarm moved on non temperature conversion");

  AST_ALARM_READ: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_20
    rd_rise && !(conv_end && conv_temp && temp_hot) |=> over_temp_alarm_n)
    else $error("alarm not released by read");

  AST_PDOWN: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_21
    conv_end && !cv_s |=> power_down)
    else $error("no power down with strobe low");

  AST_PDOWN_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_21
    power_down && !strobe_rise |=> power_down)
    else $error("power down left without strobe rise");

  AST_PDOWN_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_21
    power_down && strobe_rise |=> !power_down)
    else $error("no wake on strobe rise");

  AST_RESULT: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_25
    conv_end |=> result == $past(adc_code) && !busy)
    else $error("result not latched at end of conversion");

  AST_ERASE: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_23
    rd_fall && !conv_end |=> result == '0)
    else $error("result not erased after read");

  AST_SETTLE: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_15
    conv_end && cv_s |=> s_settling)
    else $error("settling interval wrong");

endmodule : tac_core

// ===== src/tac_pkg.sv
package tac_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int T_CONV_ADC_NS = 9000;
  localparam int T_CONV_TEMP_NS = 27000;
  localparam int T_SETTLE_NS = 100;
  localparam int CNT_W = 11;
  // exact figures, so rounding direction does not matter here
  localparam logic [CNT_W-1:0] CONV_ADC_CYC = CNT_W'(T_CONV_ADC_NS * CLK_MHZ / 1000);
  localparam logic [CNT_W-1:0] CONV_TEMP_CYC = CNT_W'(T_CONV_TEMP_NS * CLK_MHZ / 1000);
  // least time, rounded up
  localparam logic [2:0] SETTLE_CYC = 3'((T_SETTLE_NS * CLK_MHZ + 999) / 1000);

  // ----------------------------------------------------------------
  // control byte layout and register values
  // ----------------------------------------------------------------
  localparam int RES_W = 10;
  localparam int BYTE_W = 8;
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 3;
  localparam logic [4:0] SEL_ADDR = 5'h00;
  localparam logic [2:0] CH_RESET = 3'h0;
  localparam logic [7:0] THR_RESET = 8'h99;
  localparam logic [2:0] CH_TEMP = 3'h0;
  localparam logic [2:0] CH_BANDGAP = 3'h7;
  localparam logic [3:0] RD_FIRST_BIT = 4'h9;
  localparam logic [2:0] WR_LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    CV_ACQ,
    CV_CONV,
    CV_PDOWN
  } tac_conv_state_t;

endpackage : tac_pkg

// ===== src/tac_serial.sv
`timescale 1ns/100ps
module tac_serial
  import tac_pkg::*;
(
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic rd_wr,
  input wire logic serial_din,
  input wire logic [RES_W-1:0] rd_data,
  output logic serial_dout,
  output logic serial_dout_oe,
  output logic [BYTE_W-1:0] wr_byte,
  output logic wr_toggle
);

  // ----------------------------------------------------------------
  // write side: control byte shifted in on rising sclk
  // ----------------------------------------------------------------
  logic wr_rst_n;
  logic [BYTE_W-2:0] shift;
  logic [2:0] wr_cnt;
  logic [BYTE_W-2:0] next_shift;
  logic [2:0] next_wr_cnt;
  logic [BYTE_W-1:0] next_wr_byte;
  logic next_wr_toggle;

  // bit count restarts whenever the port is deselected
  assign wr_rst_n = rst_n & ~cs_n;

  // shift and hand a full byte over by a toggle
  always_comb begin
    next_shift = shift;
    next_wr_cnt = wr_cnt;
    next_wr_byte = wr_byte;
    next_wr_toggle = wr_toggle;
    if (!rd_wr) begin
      next_shift = {shift[BYTE_W-3:0], serial_din};
      next_wr_cnt = wr_cnt + 3'h1;
      // RULE_01: whole byte handed over
      if (wr_cnt == WR_LAST_BIT) begin
        next_wr_byte = {shift, serial_din};
        next_wr_toggle = ~wr_toggle;
      end
    end
  end

  always_ff @(posedge sclk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      shift <= '0;
      wr_cnt <= 3'h0;
    end else begin
      shift <= next_shift;
      wr_cnt <= next_wr_cnt;
    end
  end

  // byte stays put until the next one completes, so the core can sample it
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_byte <= 8'h00;
      wr_toggle <= 1'b0;
    end else begin
      wr_byte <= next_wr_byte;
      wr_toggle <= next_wr_toggle;
    end
  end

  // ----------------------------------------------------------------
  // read side: result shifted out on falling sclk
  // ----------------------------------------------------------------
  logic rd_rst_n;
  logic [3:0] bit_idx;
  logic first_fall;
  logic [3:0] next_bit_idx;
  logic next_first_fall;

  // index parks on the top bit while the select line is low
  assign rd_rst_n = rst_n & rd_wr;

  // first falling edge after the select rise does not advance
  always_comb begin
    next_first_fall = 1'b0;
    next_bit_idx = bit_idx;
    if (!first_fall && bit_idx != 4'h0) begin
      next_bit_idx = bit_idx - 4'h1;
    end
  end

  always_ff @(negedge sclk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      bit_idx <= RD_FIRST_BIT;
      first_fall <= 1'b1;
    end else begin
      bit_idx <= next_bit_idx;
      first_fall <= next_first_fall;
    end
  end

  // rd_data is held static by the core for the whole read
  assign serial_dout = rd_data[bit_idx];
  assign serial_dout_oe = rd_wr & ~cs_n;

endmodule : tac_serial

// ===== test/tac_core_tb_top.sv
`timescale 1ns/100ps
module tac_core_tb_top
  import tac_pkg::*;
;
  logic clk_sys;
  logic rst_n;
  logic sclk;
  logic cs_n;
  logic rd_wr;
  logic serial_din;
  logic serial_dout;
  logic convert_strobe_n;
  logic [RES_W-1:0] adc_code;
  logic [2:0] channel_sel;
  logic bandgap_sel;
  logic busy;
  logic hold;
  logic serial_dout_oe;
  logic acquire_settled;
  logic power_down;
  logic over_temp_alarm_n;
  logic [RES_W-1:0] rd;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;

  tac_core tac_core_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .rd_wr(rd_wr),
    .serial_din(serial_din), .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe),
    .convert_strobe_n(convert_strobe_n), .adc_code(adc_code), .channel_sel(channel_sel),
    .bandgap_sel(bandgap_sel), .busy(busy), .hold(hold), .acquire_settled(acquire_settled),
    .power_down(power_down), .over_temp_alarm_n(over_temp_alarm_n)
  );

  tac_host tac_host_inst (
    .sclk(sclk), .cs_n(cs_n), .rd_wr(rd_wr), .serial_din(serial_din),
    .convert_strobe_n(convert_strobe_n), .serial_dout(serial_dout)
  );

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [CNT_W-1:0] exp,
                       input logic [CNT_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_cyc

  // one conversion; busy length counted, strobe kept low for auto power down
  task automatic conv(input int len, input bit keep_low);
    int n;
    n = 0;
    tac_host_inst.start_conv();
    while (busy !== 1'b1 && n < 40) begin
      wait_cyc(1);
      n++;
    end
    check("hold_on", 11'h1, CNT_W'(hold));
    if (!keep_low) tac_host_inst.release_strobe();
    n = 0;
    while (busy === 1'b1 && n < 2000) begin
      wait_cyc(1);
      n++;
    end
    check("busy_cycles", CNT_W'(len), CNT_W'(n));
    check("hold_off", '0, CNT_W'(hold));
    wait_cyc(2);
    check("power_down", CNT_W'(keep_low), CNT_W'(power_down));
    tac_host_inst.release_strobe();
    wait_cyc(8);
    check("power_down_rel", '0, CNT_W'(power_down));
    check("acq_settled", 11'h1, CNT_W'(acquire_settled));
  endtask : conv

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("channel_sel", '0, CNT_W'(channel_sel));
    check("alarm_n", 11'h1, CNT_W'(over_temp_alarm_n));
    check("busy", '0, CNT_W'(busy));
    check("dout_oe_idle", '0, CNT_W'(serial_dout_oe));
    wait_cyc(7);
    check("acq_settled", 11'h1, CNT_W'(acquire_settled));
  endtask : t_reset

  task automatic t_channels();
    logic [2:0] codes [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h5, 3'h0};
    foreach (codes[i]) begin
      tac_host_inst.write_byte({5'h00, codes[i]});
      wait_cyc(10);
      check("channel_sel", CNT_W'(codes[i]), CNT_W'(channel_sel));
      check("bandgap_sel", CNT_W'(codes[i] == 3'h7), CNT_W'(bandgap_sel));
    end
  endtask : t_channels

  // default threshold of fifty degrees; hot, cool, hot then read
  task automatic t_alarm();
    adc_code = RES_W'((125 + 103) * 4);
    conv(27000 / 20, 1'b0);
    check("alarm_hot", '0, CNT_W'(over_temp_alarm_n));
    adc_code = RES_W'((50 + 103) * 4 + 3);
    conv(27000 / 20, 1'b0);
    check("alarm_equal", 11'h1, CNT_W'(over_temp_alarm_n));
    adc_code = RES_W'((51 + 103) * 4);
    conv(27000 / 20, 1'b0);
    check("alarm_51", '0, CNT_W'(over_temp_alarm_n));
    adc_code = '0;
    // output enable looked at early in the read, during the first sclk period before any data bit
    fork
      tac_host_inst.read_word(rd);
      begin
        #60;
        check("dout_oe", 11'h1, CNT_W'(serial_dout_oe));
      end
    join
    check("read_data", CNT_W'((51 + 103) * 4), CNT_W'(rd));
    check("alarm_read", 11'h1, CNT_W'(over_temp_alarm_n));
    tac_host_inst.read_word(rd);
    check("read_erased", '0, CNT_W'(rd));
  endtask : t_alarm

  // threshold write, then another channel must not touch the alarm
  task automatic t_threshold();
    tac_host_inst.write_byte(tac_host_inst.alarm_code(-55));
    wait_cyc(10);
    check("channel_kept", '0, CNT_W'(channel_sel));
    adc_code = RES_W'((-55 + 103 + 1) * 4);
    conv(27000 / 20, 1'b0);
    check("alarm_low_thr", '0, CNT_W'(over_temp_alarm_n));
    tac_host_inst.write_byte(8'h01);
    wait_cyc(10);
    // cool code below the threshold, nonzero so an erase would show
    adc_code = 10'h0AA;
    conv(9000 / 20, 1'b1);
    check("alarm_other_ch", '0, CNT_W'(over_temp_alarm_n));
    tac_host_inst.read_word(rd);
    check("read_ch1", CNT_W'(10'h0AA), CNT_W'(rd));
  endtask : t_threshold

  // ----------------------------------------------------------------
  // clock, reset, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ceiling well above the roughly 6600 cycles of the sequence
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    adc_code = '0;
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_reset();
    t_channels();
    t_alarm();
    t_threshold();
    end_of_test();
  end
endmodule : tac_core_tb_top

// ===== test/tac_host.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// host controller model: serial port and convert strobe
// ----------------------------------------------------------------
module tac_host
  import tac_pkg::*;
(
  output logic sclk,
  output logic cs_n,
  output logic rd_wr,
  output logic serial_din,
  output logic convert_strobe_n,
  input wire logic serial_dout
);
  // idle levels; serial clock stands still low between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    rd_wr = 1'b0;
    serial_din = 1'b0;
    convert_strobe_n = 1'b1;
  end

  task automatic write_byte(input logic [BYTE_W-1:0] b);
    #7 cs_n = 1'b0;
    rd_wr = 1'b0;
    for (int i = BYTE_W - 1; i >= 0; i--) begin
      serial_din = b[i];
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    // released line flips so stale data is never read as valid
    serial_din = ~serial_din;
  endtask : write_byte

  function automatic logic [BYTE_W-1:0] alarm_code(input int t_c);
    int t;
    t = (t_c < -55) ? -55 : ((t_c > 125) ? 125 : t_c);
    return BYTE_W'(t + 103);
  endfunction : alarm_code

  task automatic read_word(output logic [RES_W-1:0] w);
    #7 cs_n = 1'b0;
    rd_wr = 1'b1;
    // first falling edge does not advance the bit
    #40 sclk = 1'b1;
    #40 sclk = 1'b0;
    for (int i = RES_W - 1; i >= 0; i--) begin
      #40 sclk = 1'b1;
      w[i] = serial_dout;
      #40 sclk = 1'b0;
    end
    #40 rd_wr = 1'b0;
    cs_n = 1'b1;
    #100;
  endtask : read_word

  task automatic start_conv();
    #400 convert_strobe_n = 1'b0;
  endtask : start_conv

  task automatic release_strobe();
    convert_strobe_n = 1'b1;
  endtask : release_strobe
endmodule : tac_host
